// file: common/ifpb_defs.svh
// Offsets, reset values and field positions of the interrupt flag and priority bank.
// Assumes it is included by its bare name after the package.
`ifndef IFPB_DEFS_SVH
`define IFPB_DEFS_SVH
`define IFPB_OFF_CTRL2 12'h000
`define IFPB_OFF_CTRL3 12'h004
`define IFPB_OFF_FLAGS1 12'h008
`define IFPB_OFF_FLAGS2 12'h00C
`define IFPB_OFF_GLOBAL 12'h010
`define IFPB_OFF_ENABLES 12'h014
`define IFPB_RST_CTRL2 8'hFF
`define IFPB_RST_CTRL3 8'hC0
`define IFPB_RST_FLAGS 8'h00
`define IFPB_RST_GLOBAL 8'h00
`define IFPB_RST_ENABLES 8'h00
`define IFPB_FLAGS2_MASK 8'hCE
`define IFPB_FLAGS1_WMASK 8'hCB
`define IFPB_FLAGS1_RMASK 8'hFB
`define IFPB_BIT_PULLUP_DIS 7
`define IFPB_BIT_TMR0_PRIO 2
`define IFPB_BIT_INT3_PRIO 1
`define IFPB_BIT_RBCH_PRIO 0
`define IFPB_BIT_INT2_PRIO 7
`define IFPB_BIT_INT1_PRIO 6
`define IFPB_BIT_RX_FULL 5
`define IFPB_BIT_TX_EMPTY 4
`define IFPB_BIT_GIE 7
`define IFPB_BIT_PERIPHERAL_GROUP_ENABLE 6
`define IFPB_BIT_PRIO_EN 5
`endif

// file: common/ifpb_pkg.sv
// Types shared by the interrupt flag and priority bank.
// Assumes no other package.
package ifpb_pkg;
    typedef enum logic [1:0] {
        IFPB_DP_IDLE = 2'b00,
        IFPB_DP_READ = 2'b01,
        IFPB_DP_WRITE = 2'b10
    } ifpb_phase_t;
endpackage

// file: core/ifpb_bank.sv
// Interrupt control two/three and peripheral flag one/two, AHB-Lite slave.
// Assumes single-word transfers, event pulses one cycle wide on hclk.
//
// The register addresses and register access over AHB-Lite are this design's own decisions.
`include "ifpb_defs.svh"
module ifpb_bank
    import ifpb_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [3:0] ext_irq_pin,
    input wire logic [7:0] portb_latch,
    output logic [7:0] portb_pullup_en,
    input wire logic [2:0] core_src_flag,
    input wire logic [2:0] core_src_enable,
    input wire logic parallel_port_access,
    input wire logic converter_done,
    input wire logic serial_rx_full,
    input wire logic serial_rx_buffer_read,
    input wire logic serial_tx_empty,
    input wire logic serial_tx_buffer_write,
    input wire logic sync_serial_done,
    input wire logic timer2_match,
    input wire logic timer1_overflow,
    input wire logic oscillator_fail,
    input wire logic comparator_change,
    input wire logic bus_collision,
    input wire logic low_voltage,
    input wire logic timer3_overflow,
    input wire logic [7:0] periph_enable1,
    input wire logic [7:0] periph_enable2,
    input wire logic [7:0] periph_priority1,
    input wire logic [7:0] periph_priority2,
    output logic irq_high,
    output logic irq_low,
    output logic [3:0] ext_irq_edge
);
    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    ifpb_phase_t phase_q;
    logic [11:0] addr_q;
    logic [7:0] ctrl2_q;
    logic [7:0] ctrl3_q;
    logic [7:0] flags1_q;
    logic [7:0] flags2_q;
    logic [7:0] global_q;
    logic [7:0] rd_byte;
    logic wr_ctrl2, wr_ctrl3, wr_flags1, wr_flags2, wr_global;
    logic [7:0] wbyte;

    // Zero-wait slave, every access OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_q <= IFPB_DP_IDLE;
            addr_q <= 12'h000;
        end else if (hready) begin
            if (hsel && htrans[1]) begin
                phase_q <= hwrite ? IFPB_DP_WRITE : IFPB_DP_READ;
                addr_q <= haddr;
            end else begin
                phase_q <= IFPB_DP_IDLE;
            end
        end
    end

    // Data-phase write strobes
    assign wbyte = hwdata[7:0];
    assign wr_ctrl2 = (phase_q == IFPB_DP_WRITE) && (addr_q == `IFPB_OFF_CTRL2);
    assign wr_ctrl3 = (phase_q == IFPB_DP_WRITE) && (addr_q == `IFPB_OFF_CTRL3);
    assign wr_flags1 = (phase_q == IFPB_DP_WRITE) && (addr_q == `IFPB_OFF_FLAGS1);
    assign wr_flags2 = (phase_q == IFPB_DP_WRITE) && (addr_q == `IFPB_OFF_FLAGS2);
    assign wr_global = (phase_q == IFPB_DP_WRITE) && (addr_q == `IFPB_OFF_GLOBAL);

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_byte = 8'h00;
        unique case (addr_q)
            `IFPB_OFF_CTRL2: rd_byte = ctrl2_q;
            `IFPB_OFF_CTRL3: rd_byte = ctrl3_q;
            `IFPB_OFF_FLAGS1: rd_byte = flags1_q & `IFPB_FLAGS1_RMASK;
            `IFPB_OFF_FLAGS2: rd_byte = flags2_q & `IFPB_FLAGS2_MASK;
            `IFPB_OFF_GLOBAL: rd_byte = global_q;
            default: rd_byte = 8'h00;
        endcase
    end
    assign hrdata = (phase_q == IFPB_DP_READ) ? {24'h000000, rd_byte} : 32'h00000000;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Control two: pull-up disable, edges, three priorities
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl2_q <= `IFPB_RST_CTRL2;
        end else if (wr_ctrl2) begin
            ctrl2_q <= wbyte;
        end
    end

    // Global word: global enable, peripheral group enable, priority feature
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            global_q <= `IFPB_RST_GLOBAL;
        end else if (wr_global) begin
            global_q <= wbyte & 8'hE0;
        end
    end

    // Pull-ups off when disabled, else per latch
    assign portb_pullup_en = ctrl2_q[`IFPB_BIT_PULLUP_DIS] ? 8'h00 : portb_latch;

    // ------------------------------------------------------------
    // External pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q;
    logic [3:0] edge_sel;
    logic [3:0] pin_edge;

    // Three stages; change counts once second and third differ
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
            pin_s3_q <= 4'h0;
        end else begin
            pin_s1_q <= ext_irq_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // Pin 0 is bit 6 down to pin 3 at bit 3
    assign edge_sel = {ctrl2_q[3], ctrl2_q[4], ctrl2_q[5], ctrl2_q[6]};
    // Rising when select is 1, falling when 0
    assign pin_edge = (pin_s2_q ^ pin_s3_q) & ~(pin_s2_q ^ edge_sel);
    assign ext_irq_edge = pin_edge;

    // ------------------------------------------------------------
    // Control three: priorities, enables, external flags
    // ------------------------------------------------------------
    // Set wins over a software clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl3_q <= `IFPB_RST_CTRL3;
        end else begin
            if (wr_ctrl3) begin
                ctrl3_q <= wbyte | {5'h00, pin_edge[3:1]};
            end else begin
                ctrl3_q <= ctrl3_q | {5'h00, pin_edge[3:1]};
            end
        end
    end

    // ------------------------------------------------------------
    // Peripheral flags
    // ------------------------------------------------------------
    logic [7:0] set1, set2;
    logic rx_flag_q, tx_flag_q;
    logic [7:0] flags1_sw_q;

    assign set1 = {parallel_port_access,
                   converter_done,
                   2'b00, sync_serial_done,
                   1'b0, timer2_match,
                   timer1_overflow};
    assign set2 = {oscillator_fail,
                   comparator_change,
                   2'b00, bus_collision,
                   low_voltage,
                   timer3_overflow,
                   1'b0};

    // Sticky flags; one driver, read-only and unimplemented positions kept zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags1_sw_q <= `IFPB_RST_FLAGS;
        end else if (wr_flags1) begin
            flags1_sw_q <= (wbyte | set1) & `IFPB_FLAGS1_WMASK;
        end else begin
            flags1_sw_q <= (flags1_sw_q | set1) & `IFPB_FLAGS1_WMASK;
        end
    end

    // Receive full clears on buffer read; transmit empty clears on buffer write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_flag_q <= 1'b0;
            tx_flag_q <= 1'b0;
        end else begin
            rx_flag_q <= serial_rx_full & ~serial_rx_buffer_read;
            tx_flag_q <= serial_tx_empty & ~serial_tx_buffer_write;
        end
    end
    // Status bits merged in here so the sticky register has one driver
    assign flags1_q = flags1_sw_q | {2'b00, rx_flag_q, tx_flag_q, 4'h0};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags2_q <= `IFPB_RST_FLAGS;
        end else if (wr_flags2) begin
            flags2_q <= (wbyte | set2) & `IFPB_FLAGS2_MASK;
        end else begin
            flags2_q <= (flags2_q | set2) & `IFPB_FLAGS2_MASK;
        end
    end

    // ------------------------------------------------------------
    // Request and priority routing
    // ------------------------------------------------------------
    // Pending vectors: core sources are timer0, int0, port change
    logic [2:0] ext_pend, ext_prio;
    logic [2:0] core_pend, core_prio;
    logic [7:0] per_pend1, per_pend2;
    logic prio_en, global_irq_enable, peripheral_group_enable;
    logic hi_any, lo_any, per_any;

    assign prio_en = global_q[`IFPB_BIT_PRIO_EN];
    assign global_irq_enable = global_q[`IFPB_BIT_GIE];
    assign peripheral_group_enable = global_q[`IFPB_BIT_PERIPHERAL_GROUP_ENABLE];
    assign ext_pend = ctrl3_q[2:0] & ctrl3_q[5:3];
    assign ext_prio = {ctrl2_q[`IFPB_BIT_INT3_PRIO], ctrl3_q[`IFPB_BIT_INT2_PRIO],
                       ctrl3_q[`IFPB_BIT_INT1_PRIO]};
    assign core_pend = core_src_flag & core_src_enable;
    // Int0 is always high priority
    assign core_prio = {ctrl2_q[`IFPB_BIT_TMR0_PRIO], 1'b1, ctrl2_q[`IFPB_BIT_RBCH_PRIO]};
    assign per_pend1 = flags1_q & periph_enable1 & 8'hFB;
    assign per_pend2 = flags2_q & periph_enable2;

    // Compatibility: one vector, peripherals gated as a group
    always_comb begin
        hi_any = 1'b0;
        lo_any = 1'b0;
        per_any = |per_pend1 | |per_pend2;
        if (prio_en) begin
            hi_any = |(ext_pend & ext_prio) | |(core_pend & core_prio)
                | |(per_pend1 & periph_priority1) | |(per_pend2 & periph_priority2);
            lo_any = |(ext_pend & ~ext_prio) | |(core_pend & ~core_prio)
                | |(per_pend1 & ~periph_priority1) | |(per_pend2 & ~periph_priority2);
        end else begin
            hi_any = |ext_pend | |core_pend | (peripheral_group_enable & per_any);
        end
    end

    // High request reaches the core only under the global enable; low under priority and group enables
    assign irq_high = global_irq_enable & hi_any;
    assign irq_low = prio_en & peripheral_group_enable & lo_any;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_pullup_off: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl2_q[7] |-> portb_pullup_en == 8'h00) else $error("pull-ups not off");
    a_ext_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
        pin_edge[1] |=> ctrl3_q[0]) else $error("ext1 flag not set");
    a_rise_edge: assert property (@(posedge hclk) disable iff (!hresetn)
        (pin_s2_q[2] && !pin_s3_q[2] && ctrl2_q[4]) |=> ctrl3_q[1])
        else $error("rising edge missed");
    a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        (flags1_q[0] && !wr_flags1) |=> flags1_q[0]) else $error("timer1 flag lost");
    a_flag_poll: assert property (@(posedge hclk) disable iff (!hresetn)
        (timer3_overflow && periph_enable2 == 8'h00) |=> flags2_q[1])
        else $error("timer3 flag not set");
    a_rx_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        serial_rx_buffer_read |=> !flags1_q[5]) else $error("rx flag not cleared");
    a_tx_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        serial_tx_buffer_write |=> !flags1_q[4]) else $error("tx flag not cleared");
    a_unimpl_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        flags2_q[5:4] == 2'b00 && flags2_q[0] == 1'b0 && flags1_q[2] == 1'b0)
        else $error("unimplemented bit set");
    a_compat_low: assert property (@(posedge hclk) disable iff (!hresetn)
        !prio_en |-> !irq_low) else $error("low vector in compat mode");
    a_group_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        (!prio_en && !peripheral_group_enable && ext_pend == 3'b000 && core_pend == 3'b000) |-> !irq_high)
        else $error("peripheral not gated");

    // ------------------------------------------------------------
    // Further checks: edges, event flags, routing
    // ------------------------------------------------------------
    // Falling edge on pin 3 with falling select must set its flag
    a_fall_edge: assert property (@(posedge hclk) disable iff (!hresetn)
        (pin_s3_q[3] && !pin_s2_q[3] && !ctrl2_q[3]) |=> ctrl3_q[2])
        else $error("falling edge missed");

    a_ext2_set: assert property (@(posedge hclk) disable iff (!hresetn)
        pin_edge[2] |=> ctrl3_q[1]) else $error("ext2 flag not set");

    // Each event pulse must land in its flag the next cycle
    a_parallel_set: assert property (@(posedge hclk) disable iff (!hresetn)
        parallel_port_access |=> flags1_q[7]) else $error("parallel flag not set");

    a_conv_set: assert property (@(posedge hclk) disable iff (!hresetn)
        converter_done |=> flags1_q[6]) else $error("converter flag not set");

    a_sync_set: assert property (@(posedge hclk) disable iff (!hresetn)
        sync_serial_done |=> flags1_q[3]) else $error("sync serial flag not set");

    a_timer2_set: assert property (@(posedge hclk) disable iff (!hresetn)
        timer2_match |=> flags1_q[1]) else $error("timer2 flag not set");

    a_osc_set: assert property (@(posedge hclk) disable iff (!hresetn)
        oscillator_fail |=> flags2_q[7]) else $error("oscillator flag not set");

    a_comp_set: assert property (@(posedge hclk) disable iff (!hresetn)
        comparator_change |=> flags2_q[6]) else $error("comparator flag not set");

    a_collision_set: assert property (@(posedge hclk) disable iff (!hresetn)
        bus_collision |=> flags2_q[3]) else $error("collision flag not set");

    a_lowvolt_set: assert property (@(posedge hclk) disable iff (!hresetn)
        low_voltage |=> flags2_q[2]) else $error("low voltage flag not set");

    // Routing: enables gate, priority bits steer, global enable gates the high request only
    a_ext_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl3_q[5:3] == 3'b000 && core_pend == 3'b000 && per_pend1 == 8'h00
         && per_pend2 == 8'h00) |-> (!irq_high && !irq_low))
        else $error("disabled source requested");

    a_ext1_high: assert property (@(posedge hclk) disable iff (!hresetn)
        (prio_en && global_irq_enable && ext_pend[0] && ctrl3_q[6]) |-> irq_high)
        else $error("ext1 high request missing");

    a_timer0_high: assert property (@(posedge hclk) disable iff (!hresetn)
        (prio_en && global_irq_enable && core_pend[2] && ctrl2_q[2]) |-> irq_high)
        else $error("timer0 high request missing");

    a_global_off: assert property (@(posedge hclk) disable iff (!hresetn)
        !global_irq_enable |-> !irq_high) else $error("request without global enable");
endmodule // ifpb_bank

// file: bench/ifpb_periph_model.sv
// Model of the peripherals and serial buffers that feed the flag bank.
// Assumes the bench raises one fire bit for one cycle per request.
module ifpb_periph_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [13:0] fire,
    output logic [9:0] evt,
    output logic rx_full,
    output logic rx_read,
    output logic tx_empty,
    output logic tx_write
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Event sources
    // ----------------------------------------
    // One-cycle pulses launched on the clock, as real sources do
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt <= 10'h000;
            rx_read <= 1'b0;
            tx_write <= 1'b0;
        end else begin
            evt <= fire[9:0];
            rx_read <= fire[11];
            tx_write <= fire[12];
        end
    end
    // Buffer state; transmit side starts empty, so its flag is up after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_full <= 1'b0;
            tx_empty <= 1'b1;
        end else begin
            rx_full <= (rx_full | fire[10]) & ~fire[11];
            tx_empty <= (tx_empty | fire[13]) & ~fire[12];
        end
    end
endmodule // ifpb_periph_model

// file: bench/ifpb_bank_tb.sv
// Self-checking bench for the interrupt flag and priority bank.
// Assumes a single AHB-Lite slave, so hreadyout feeds hready back.
`include "ifpb_defs.svh"
module ifpb_bank_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [11:0] C2 = `IFPB_OFF_CTRL2;
    localparam logic [11:0] C3 = `IFPB_OFF_CTRL3;
    localparam logic [11:0] F1 = `IFPB_OFF_FLAGS1;
    localparam logic [11:0] F2 = `IFPB_OFF_FLAGS2;
    localparam logic [11:0] GL = `IFPB_OFF_GLOBAL;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq_high, irq_low, rx_full, rx_read;
    logic tx_empty, tx_write, rd_ph = 1'b0;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize, csf, cse;
    logic [31:0] hwdata, hrdata;
    logic [3:0] ext_irq_pin, ext_irq_edge;
    logic [7:0] portb_latch, portb_pullup_en, pe1, pp1, r;
    logic [7:0] fbit [10] = '{7, 6, 3, 1, 0, 7, 6, 3, 2, 1};
    logic [13:0] fire;
    logic [9:0] evt;
    logic [7:0] exp_q [$];
    int fail_count = 0, n_tests = 0, edge_cnt = 0, c0;
    ifpb_bank uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_irq_pin, .portb_latch,
        .portb_pullup_en, .core_src_flag(csf), .core_src_enable(cse),
        .parallel_port_access(evt[0]), .converter_done(evt[1]), .serial_rx_full(rx_full),
        .serial_rx_buffer_read(rx_read), .serial_tx_empty(tx_empty),
        .serial_tx_buffer_write(tx_write), .sync_serial_done(evt[2]), .timer2_match(evt[3]),
        .timer1_overflow(evt[4]), .oscillator_fail(evt[5]), .comparator_change(evt[6]),
        .bus_collision(evt[7]), .low_voltage(evt[8]), .timer3_overflow(evt[9]),
        .periph_enable1(pe1), .periph_enable2(8'h00), .periph_priority1(pp1),
        .periph_priority2(8'h00), .irq_high, .irq_low, .ext_irq_edge);
    ifpb_periph_model peer (.hclk, .hresetn, .fire, .evt, .rx_full, .rx_read, .tx_empty,
        .tx_write);
    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Read data taken at the edge closing the data phase, oldest note first
    always @(posedge hclk) begin
        if (rd_ph) begin
            check(hrdata[7:0], exp_q.pop_front());
            check({7'h00, hresp}, 8'h00);
        end
        rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
    end
    // Qualified pin edges, counted so a double trigger is caught
    always @(posedge hclk) edge_cnt <= edge_cnt + $countones(ext_irq_edge);
    // Single word transfer; holds each phase until hready is seen high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'b10;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00; hwdata <= {24'h000000, d};
        if (!w) exp_q.push_back(d);
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic pulse(input int k);
        fire[k] <= 1'b1;
        cyc(1);
        fire <= 14'h0000;
        cyc(3);
    endtask
    task automatic irq_is(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
        xfer(1'b1, a, d);
        cyc(1);
        #1 check({6'h00, irq_high, irq_low}, {6'h00, e});
    endtask
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // Watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        cyc(20000);
        fail_count++;
        conclude();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 12'h000; htrans = 2'b00; hwrite = 1'b0;
        hsize = 3'b010; hwdata = 32'h0; ext_irq_pin = 4'h0; csf = 3'h0; cse = 3'h0;
        pe1 = 8'h00; pp1 = 8'h00; fire = 14'h0000;
        r = 8'($urandom(33185));
        portb_latch = 8'($urandom);
        cyc(10);
        hresetn <= 1'b1;
        xfer(1'b0, C2, `IFPB_RST_CTRL2);
        xfer(1'b0, C3, `IFPB_RST_CTRL3);
        xfer(1'b0, F1, 8'h10);
        xfer(1'b0, F2, 8'h00);
        xfer(1'b0, 12'h018, 8'h00);
        check(portb_pullup_en, 8'h00);
        // Random control two, pull-up disable both ways
        for (int i = 0; i < 2; i++) begin
            r = {i[0], 7'($urandom)};
            xfer(1'b1, C2, r);
            xfer(1'b0, C2, r);
            check(portb_pullup_en, r[7] ? 8'h00 : portb_latch);
        end
        // Pins 1 to 3, each edge: one flag set, still set after the opposite edge
        for (int n = 1; n <= 3; n++) begin
            for (int e = 0; e < 2; e++) begin
                ext_irq_pin[n] <= ~e[0];
                r = 8'h80;
                r[6 - n] = e[0];
                xfer(1'b1, C2, r);
                cyc(6);
                xfer(1'b1, C3, 8'hC0);
                c0 = edge_cnt;
                ext_irq_pin[n] <= e[0];
                cyc(6);
                xfer(1'b0, C3, 8'hC0 | (8'h01 << (n - 1)));
                check(8'(edge_cnt - c0), 8'h01);
                ext_irq_pin[n] <= ~e[0];
                cyc(6);
                xfer(1'b0, C3, 8'hC0 | (8'h01 << (n - 1)));
                xfer(1'b1, C3, 8'hC0);
                xfer(1'b0, C3, 8'hC0);
            end
        end
        // Every peripheral event with all enables off, then software clear
        for (int k = 0; k < 10; k++) begin
            pulse(k);
            xfer(1'b0, k < 5 ? F1 : F2, (8'h01 << fbit[k]) | (k < 5 ? 8'h10 : 8'h00));
            xfer(1'b1, k < 5 ? F1 : F2, 8'h00);
            xfer(1'b0, k < 5 ? F1 : F2, k < 5 ? 8'h10 : 8'h00);
        end
        // Unimplemented and read-only positions ignore writes
        xfer(1'b1, F2, 8'hFF);
        xfer(1'b0, F2, 8'hCE);
        xfer(1'b1, F2, 8'h00);
        xfer(1'b1, F1, 8'hFF);
        xfer(1'b0, F1, 8'hDB);
        xfer(1'b1, F1, 8'h00);
        // Receive and transmit flags follow buffer accesses
        pulse(10);
        xfer(1'b0, F1, 8'h30);
        pulse(11);
        xfer(1'b0, F1, 8'h10);
        pulse(12);
        xfer(1'b0, F1, 8'h00);
        pulse(13);
        xfer(1'b0, F1, 8'h10);
        // Timer-1 request through group enable and priority modes
        pulse(4);
        pe1 <= 8'h01;
        irq_is(GL, 8'h00, 2'b00);
        irq_is(GL, 8'h80, 2'b00);
        irq_is(GL, 8'hC0, 2'b10);
        irq_is(GL, 8'hE0, 2'b01);
        pp1 <= 8'h01;
        irq_is(GL, 8'hA0, 2'b10);
        pe1 <= 8'h00;
        irq_is(GL, 8'hE0, 2'b00);
        xfer(1'b1, F1, 8'h00);
        // External interrupt one priority and enable, timer-0 priority
        irq_is(C3, 8'h09, 2'b01);
        irq_is(C3, 8'h49, 2'b10);
        irq_is(C3, 8'h41, 2'b00);
        csf <= 3'b100;
        cse <= 3'b100;
        irq_is(C2, 8'h80, 2'b01);
        irq_is(C2, 8'h84, 2'b10);
        cyc(2);
        conclude();
    end
endmodule // ifpb_bank_tb
